// ---- common/aux_route_pkg.sv ----
// Constants for the auxiliary route and termination pulse control block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port.
package aux_route_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFS_AUX_SWITCH_MODES    = 8'h00;
   localparam logic [7:0] OFS_RECEIVER_SETTINGS   = 8'h04;
   localparam logic [7:0] OFS_TERM_PULSE_SELECT_1 = 8'h08;
   localparam logic [7:0] OFS_TERM_PULSE_SELECT_2 = 8'h0c;
   localparam logic [7:0] OFS_TERM_STATUS         = 8'h10;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int AUX_ENABLE_BIT   = 6;
   localparam int AUX_MODE_LSB     = 4;
   localparam int AUX_SELECT_LSB   = 0;
   localparam int TERM_ENABLE_BIT  = 0;
   localparam int STATUS_PULSE_BIT = 16;

   // ****************************************************************
   // Route modes
   // ****************************************************************
   localparam logic [1:0] MODE_QUAD    = 2'h0;
   localparam logic [1:0] MODE_DUAL    = 2'h1;
   localparam logic [1:0] MODE_SINGLE  = 2'h2;
   localparam logic [1:0] MODE_ILLEGAL = 2'h3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic       RST_AUX_ENABLE  = 1'b1;
   localparam logic [1:0] RST_AUX_MODE    = 2'h0;
   localparam logic [3:0] RST_AUX_SELECT  = 4'h0;
   localparam logic       RST_TERM_ENABLE = 1'b1;
   localparam logic [7:0] RST_PULSE_SEL   = 8'h00;

   // ****************************************************************
   // Bus responses
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          CLK_HZ       = 200_000_000;
   localparam int          PULSE_MS     = 100;
   localparam logic [24:0] PULSE_CYCLES = 25'(PULSE_MS * (CLK_HZ / 1000));

endpackage

// ---- src/aux_route_and_term_pulse_ctrl.sv ----
// Auxiliary route decode and input termination pulse control, AXI4-Lite slave.
// Assumes hs_source_select comes from logic on sys_clk; no synchroniser needed.
// Operation
// R1: Two-bit mode picks quad 4:1, dual 8:1 or single 16:1 routing.
// R2: A write of mode 11 is ignored; the previous mode stays.
// R3: Quad mode: select bits 1:0 route all four channels of A..D.
// R4: Dual mode: bit 2 picks A/C or B/D, bits 1:0 pick channel.
// R5: Single mode: four-bit select picks one of sixteen channels A0..D3.
// R6: Termination enable 0 disconnects every high speed input termination.
// R7: Termination enable 1 connects terminations, pulses still apply per channel.
// R8: Channel with pulse bit 0 stays connected across source switches.
// R9: Channel with pulse bit 1 disconnects 100 ms per switch, then reconnects.
// R10: Pulse bits 0-3 B0-B3, 4-7 A0-A3, 8-11 C3-C0, 12-15 D3-D0.
// R11: Auxiliary enable 0 leaves every auxiliary channel disconnected.
// R12: Any change of high speed source starts a clock-counted disconnect.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module aux_route_and_term_pulse_ctrl #(
   parameter logic [24:0] PULSE_CYCLES = aux_route_pkg::PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // High speed source in use
   input  wire logic [3:0]  hs_source_select,
   // Switch controls, channel index source*4+n for A0..D3
   output logic [15:0]      aux_channel_on,
   output logic [1:0]       aux_route_mode,
   output logic [15:0]      term_connected
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic        aux_enable_reg;
   logic [1:0]  aux_route_mode_reg;
   logic [3:0]  aux_source_select_reg;
   logic        input_term_enable_reg;
   logic [15:0] term_pulse_on_switch_reg;
   logic [15:0] aux_channel_on_reg;
   logic [15:0] aux_channel_on_next;
   logic [15:0] term_connected_reg;
   logic [15:0] pulse_chan_mask;
   logic [3:0]  hs_source_prev_reg;
   logic        pulse_active_reg;
   logic [24:0] pulse_cnt_reg;
   logic        source_switch;

   logic        aw_hold_reg;
   logic        aw_hold_next;
   logic        w_hold_reg;
   logic        w_hold_next;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        do_write;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        wr_mapped;

   assign s_axi_awready  = awready_reg;
   assign s_axi_wready   = wready_reg;
   assign s_axi_bvalid   = bvalid_reg;
   assign s_axi_bresp    = bresp_reg;
   assign s_axi_arready  = arready_reg;
   assign s_axi_rvalid   = rvalid_reg;
   assign s_axi_rdata    = rdata_reg;
   assign s_axi_rresp    = rresp_reg;
   assign aux_channel_on = aux_channel_on_reg;
   assign aux_route_mode = aux_route_mode_reg;
   assign term_connected = term_connected_reg;

   // ****************************************************************
   // Write channel capture
   // ****************************************************************
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next  = w_hold_reg;
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            aw_hold_next = 1'b1;
         end
         if (s_axi_wvalid && wready_reg) begin
            w_hold_next = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg  <= w_hold_next;
         awready_reg <= ~aw_hold_next;
         wready_reg  <= ~w_hold_next;
         if (s_axi_awvalid && awready_reg) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_reg) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
      end
   end

   assign wr_mapped = (awaddr_reg == aux_route_pkg::OFS_AUX_SWITCH_MODES)
                    | (awaddr_reg == aux_route_pkg::OFS_RECEIVER_SETTINGS)
                    | (awaddr_reg == aux_route_pkg::OFS_TERM_PULSE_SELECT_1)
                    | (awaddr_reg == aux_route_pkg::OFS_TERM_PULSE_SELECT_2)
                    | (awaddr_reg == aux_route_pkg::OFS_TERM_STATUS);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= aux_route_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? aux_route_pkg::RESP_OKAY : aux_route_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_enable_reg           <= aux_route_pkg::RST_AUX_ENABLE;
         aux_route_mode_reg       <= aux_route_pkg::RST_AUX_MODE;
         aux_source_select_reg    <= aux_route_pkg::RST_AUX_SELECT;
         input_term_enable_reg    <= aux_route_pkg::RST_TERM_ENABLE;
         term_pulse_on_switch_reg <= {aux_route_pkg::RST_PULSE_SEL, aux_route_pkg::RST_PULSE_SEL};
      end else if (do_write && wstrb_reg[0]) begin
         case (awaddr_reg)
            aux_route_pkg::OFS_AUX_SWITCH_MODES: begin
               aux_enable_reg        <= wdata_reg[aux_route_pkg::AUX_ENABLE_BIT];
               aux_source_select_reg <= wdata_reg[aux_route_pkg::AUX_SELECT_LSB +: 4];
               // Illegal mode code leaves the mode as it was
               if (wdata_reg[aux_route_pkg::AUX_MODE_LSB +: 2] != aux_route_pkg::MODE_ILLEGAL) begin // [R2]
                  aux_route_mode_reg <= wdata_reg[aux_route_pkg::AUX_MODE_LSB +: 2];
               end
            end
            aux_route_pkg::OFS_RECEIVER_SETTINGS: begin
               input_term_enable_reg <= wdata_reg[aux_route_pkg::TERM_ENABLE_BIT];
            end
            aux_route_pkg::OFS_TERM_PULSE_SELECT_1: begin
               term_pulse_on_switch_reg[7:0] <= wdata_reg[7:0];
            end
            aux_route_pkg::OFS_TERM_PULSE_SELECT_2: begin
               term_pulse_on_switch_reg[15:8] <= wdata_reg[7:0];
            end
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= aux_route_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= aux_route_pkg::RESP_OKAY;
         case (s_axi_araddr)
            aux_route_pkg::OFS_AUX_SWITCH_MODES: begin
               rdata_reg <= {25'h0, aux_enable_reg, aux_route_mode_reg, aux_source_select_reg};
            end
            aux_route_pkg::OFS_RECEIVER_SETTINGS: begin
               rdata_reg <= {31'h0, input_term_enable_reg};
            end
            aux_route_pkg::OFS_TERM_PULSE_SELECT_1: begin
               rdata_reg <= {24'h0, term_pulse_on_switch_reg[7:0]};
            end
            aux_route_pkg::OFS_TERM_PULSE_SELECT_2: begin
               rdata_reg <= {24'h0, term_pulse_on_switch_reg[15:8]};
            end
            aux_route_pkg::OFS_TERM_STATUS: begin
               rdata_reg <= {15'h0, pulse_active_reg, term_connected_reg};
            end
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= aux_route_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg) begin
         if (s_axi_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end else begin
         arready_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Auxiliary route decode
   // ****************************************************************
   always_comb begin
      aux_channel_on_next = 16'h0000;
      if (aux_enable_reg) begin // [R11]
         case (aux_route_mode_reg) // [R1]
            aux_route_pkg::MODE_QUAD: begin
               aux_channel_on_next = 16'h000f << {aux_source_select_reg[1:0], 2'b00}; // [R3]
            end
            aux_route_pkg::MODE_DUAL: begin
               // Lower lines from A or B, upper lines from C or D
               aux_channel_on_next = 16'h0101 << {aux_source_select_reg[2], aux_source_select_reg[1:0]}; // [R4]
            end
            aux_route_pkg::MODE_SINGLE: begin
               aux_channel_on_next = 16'h0001 << aux_source_select_reg; // [R5]
            end
            default: begin
               aux_channel_on_next = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_channel_on_reg <= 16'h0000;
      end else begin
         aux_channel_on_reg <= aux_channel_on_next;
      end
   end

   // ****************************************************************
   // Termination pulse control
   // ****************************************************************
   // Pulse select bits to channel order A0..D3
   always_comb begin
      pulse_chan_mask = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         pulse_chan_mask[4 + k]  = term_pulse_on_switch_reg[k];      // [R10]
         pulse_chan_mask[k]      = term_pulse_on_switch_reg[4 + k];  // [R10]
         pulse_chan_mask[11 - k] = term_pulse_on_switch_reg[8 + k];  // [R10]
         pulse_chan_mask[15 - k] = term_pulse_on_switch_reg[12 + k]; // [R10]
      end
   end

   assign source_switch = (hs_source_select != hs_source_prev_reg); // [R12]
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_source_prev_reg <= 4'h0;
         pulse_active_reg   <= 1'b0;
         pulse_cnt_reg      <= 25'h0;
      end else begin
         hs_source_prev_reg <= hs_source_select;
         // A new switch restarts the full interval
         if (source_switch) begin // [R9] [R12]
            pulse_active_reg <= 1'b1;
            pulse_cnt_reg    <= 25'h0;
         end else if (pulse_active_reg) begin
            if (pulse_cnt_reg == PULSE_CYCLES - 25'h1) begin
               pulse_active_reg <= 1'b0;
            end else begin
               pulse_cnt_reg <= pulse_cnt_reg + 25'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         term_connected_reg <= 16'h0000;
      end else if (!input_term_enable_reg) begin
         term_connected_reg <= 16'h0000; // [R6]
      end else begin
         term_connected_reg <= ~(pulse_chan_mask & {16{pulse_active_reg}}); // [R7] [R8] [R9]
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   mode_illegal_kept_a: assert property ( // [R2]
      (do_write && wstrb_reg[0] && awaddr_reg == aux_route_pkg::OFS_AUX_SWITCH_MODES
       && wdata_reg[5:4] == aux_route_pkg::MODE_ILLEGAL) |=> $stable(aux_route_mode_reg))
      else $error("Illegal mode code changed the mode");
   mode_never_illegal_a: assert property ( // [R1]
      aux_route_mode_reg != aux_route_pkg::MODE_ILLEGAL)
      else $error("Mode register holds illegal code");
   quad_route_a: assert property ( // [R3]
      (aux_enable_reg && aux_route_mode_reg == aux_route_pkg::MODE_QUAD)
      |=> aux_channel_on_reg == (16'h000f << {$past(aux_source_select_reg[1:0]), 2'b00}))
      else $error("Quad route wrong");
   dual_route_a: assert property ( // [R4]
      (aux_enable_reg && aux_route_mode_reg == aux_route_pkg::MODE_DUAL)
      |=> $countones(aux_channel_on_reg) == 2
          && aux_channel_on_reg[8 + {$past(aux_source_select_reg[2]), $past(aux_source_select_reg[1:0])}])
      else $error("Dual route wrong");
   single_route_a: assert property ( // [R5]
      (aux_enable_reg && aux_route_mode_reg == aux_route_pkg::MODE_SINGLE)
      |=> $onehot(aux_channel_on_reg) && aux_channel_on_reg[$past(aux_source_select_reg)])
      else $error("Single route wrong");
   aux_disabled_a: assert property ( // [R11]
      !aux_enable_reg |=> aux_channel_on_reg == 16'h0000)
      else $error("Auxiliary channel on while disabled");
   term_off_a: assert property ( // [R6]
      !input_term_enable_reg |=> term_connected_reg == 16'h0000)
      else $error("Termination connected while disabled");
   term_steady_a: assert property ( // [R8]
      (input_term_enable_reg && pulse_chan_mask == 16'h0000) |=> term_connected_reg == 16'hffff)
      else $error("Unpulsed channel disconnected");
   pulse_start_a: assert property ( // [R12]
      (source_switch && input_term_enable_reg && pulse_chan_mask[0]
       ##1 input_term_enable_reg && pulse_chan_mask[0]) |=> !term_connected_reg[0])
      else $error("Switch did not start disconnect");
   pulse_length_a: assert property ( // [R9]
      $fell(pulse_active_reg) |-> $past(pulse_cnt_reg) == PULSE_CYCLES - 25'h1)
      else $error("Disconnect interval length wrong");
   pulse_map_a: assert property ( // [R10]
      (pulse_active_reg && input_term_enable_reg && term_pulse_on_switch_reg[8])
      |=> !term_connected_reg[11])
      else $error("Pulse bit 8 did not act on C3");

   cover_quad_c: cover property (aux_enable_reg && aux_route_mode_reg == aux_route_pkg::MODE_QUAD
                                 ##1 aux_channel_on_reg == 16'hf000);
   cover_single_c: cover property (aux_route_mode_reg == aux_route_pkg::MODE_SINGLE
                                   ##1 aux_channel_on_reg == 16'h8000);
   cover_pulse_c: cover property ($fell(pulse_active_reg) && input_term_enable_reg);
   cover_illegal_c: cover property (do_write && wdata_reg[5:4] == aux_route_pkg::MODE_ILLEGAL
                                    && awaddr_reg == aux_route_pkg::OFS_AUX_SWITCH_MODES);

endmodule

// ---- sim/aux_route_and_term_pulse_ctrl_tb.sv ----
// Self-checking bench for the auxiliary route and termination pulse control block.
// Assumes the design package is compiled first; pulse length shortened by parameter.
`timescale 1ns/1ps
module aux_route_and_term_pulse_ctrl_tb;
   localparam logic [24:0] P_CYC = 25'd16;
   logic        sys_clk;
   logic        rst_n;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic [3:0]  hs_source_select;
   logic [15:0] aux_channel_on;
   logic [1:0]  aux_route_mode;
   logic [15:0] term_connected;
   int          n_mismatch;
   int          total_checks;
   int          seed;
   logic [31:0] rd;
   logic [1:0]  rs;
   logic        en_m;
   logic [1:0]  mode_m;
   logic [3:0]  sel_m;
   logic [15:0] mask;
   logic [7:0]  wv;

   aux_route_and_term_pulse_ctrl #(.PULSE_CYCLES(P_CYC)) i_aux_route_and_term_pulse_ctrl (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .hs_source_select(hs_source_select), .aux_channel_on(aux_channel_on),
      .aux_route_mode(aux_route_mode), .term_connected(term_connected));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ****************************************************************
   // Checking and expectations
   // ****************************************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic timeout();
      n_mismatch++;
      $display("CHECK FAILED bus wait expected answer seen none");
      report_and_stop();
   endtask

   function automatic logic [15:0] aux_exp(logic en, logic [1:0] m, logic [3:0] s);
      logic [15:0] v;
      v = 16'h0000;
      if (en) begin
         case (m)
            2'h0: v[{s[1:0], 2'b00} +: 4] = 4'hf;
            2'h1: begin
               v[{s[2], s[1:0]}] = 1'b1;
               v[{1'b1, s[2], s[1:0]}] = 1'b1;
            end
            2'h2: v[s] = 1'b1;
            default: v = 16'h0000;
         endcase
      end
      return v;
   endfunction

   function automatic logic [15:0] pmap(logic [15:0] p);
      logic [15:0] c;
      for (int k = 0; k < 4; k++) begin
         c[4 + k]  = p[k];
         c[k]      = p[4 + k];
         c[11 - k] = p[8 + k];
         c[15 - k] = p[12 + k];
      end
      return c;
   endfunction

   // ****************************************************************
   // Register bus master
   // ****************************************************************
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (n > 100) timeout();
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (n > 100) timeout();
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      seed = 93354;
      n_mismatch = 0;
      total_checks = 0;
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      hs_source_select = 4'h0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check("aux_channel_on", aux_channel_on, 32'h000f);
      check("term_connected", term_connected, 32'hffff);
      axi_read(aux_route_pkg::OFS_AUX_SWITCH_MODES, rd, rs);
      check("switch modes reset", rd, 32'h40);
      axi_read(aux_route_pkg::OFS_RECEIVER_SETTINGS, rd, rs);
      check("receiver reset", rd, 32'h01);
      axi_read(aux_route_pkg::OFS_TERM_PULSE_SELECT_2, rd, rs);
      check("pulse select 2 reset", rd, 32'h00);
      $display("test reset done");
      en_m = 1'b1;
      mode_m = 2'h0;
      for (int i = 0; i < 48; i++) begin
         wv = 8'($random(seed));
         if (i < 4) wv = {2'b01, i[1:0], 4'h9};
         if (i == 4) wv = 8'h2f;
         axi_write(aux_route_pkg::OFS_AUX_SWITCH_MODES, {24'h0, wv}, rs);
         en_m = wv[6];
         sel_m = wv[3:0];
         if (wv[5:4] != 2'h3) mode_m = wv[5:4];
         repeat (2) @(posedge sys_clk);
         check("aux_route_mode", aux_route_mode, mode_m);
         check("aux_channel_on", aux_channel_on, aux_exp(en_m, mode_m, sel_m));
         axi_read(aux_route_pkg::OFS_AUX_SWITCH_MODES, rd, rs);
         check("switch modes readback", rd, {25'h0, en_m, mode_m, sel_m});
      end
      $display("test aux routing done");
      axi_write(8'h20, 32'h55, rs);
      check("unmapped write resp", rs, aux_route_pkg::RESP_SLVERR);
      axi_read(8'h20, rd, rs);
      check("unmapped read resp", rs, aux_route_pkg::RESP_SLVERR);
      check("unmapped read data", rd, 32'h0);
      $display("test unmapped done");
      for (int i = 0; i < 6; i++) begin
         mask = 16'($random(seed));
         if (i == 0) mask = 16'h0001;
         if (i == 1) mask = 16'h0f00;
         axi_write(aux_route_pkg::OFS_TERM_PULSE_SELECT_1, {24'h0, mask[7:0]}, rs);
         axi_write(aux_route_pkg::OFS_TERM_PULSE_SELECT_2, {24'h0, mask[15:8]}, rs);
         axi_read(aux_route_pkg::OFS_TERM_PULSE_SELECT_2, rd, rs);
         check("pulse select 2", rd, {24'h0, mask[15:8]});
         @(posedge sys_clk);
         hs_source_select <= hs_source_select + 4'h1;
         repeat (4) @(posedge sys_clk);
         check("term during pulse", term_connected, {16'h0, ~pmap(mask)});
         repeat (12) @(posedge sys_clk);
         check("term late pulse", term_connected, {16'h0, ~pmap(mask)});
         repeat (8) @(posedge sys_clk);
         check("term after pulse", term_connected, 32'hffff);
         axi_read(aux_route_pkg::OFS_TERM_STATUS, rd, rs);
         check("status after pulse", rd, 32'h0000_ffff);
      end
      $display("test termination pulse done");
      axi_write(aux_route_pkg::OFS_RECEIVER_SETTINGS, 32'h0, rs);
      repeat (2) @(posedge sys_clk);
      check("term disabled", term_connected, 32'h0000);
      axi_write(aux_route_pkg::OFS_RECEIVER_SETTINGS, 32'h1, rs);
      repeat (2) @(posedge sys_clk);
      check("term enabled", term_connected, 32'hffff);
      $display("test termination enable done");
      report_and_stop();
   end
endmodule
